// ==== verilog/pwm_core_pkg.sv ====
`default_nettype none
package pwm_core_pkg;
   // structure of the core
   localparam int NGEN = 4;
   localparam int TB_W = 13;
   localparam int DUTY_W = 16;
   localparam int FINE_W = 3;
   localparam int ROLL_W = 6;
   localparam int DIV_W = 3;
   localparam int SRC_W = 3;
   localparam int NSRC = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // time base clock: one count per rising pclk edge
   localparam int PCLK_HZ = 20_000_000;
   localparam int TB_STEP_PS = 1_000_000_000 / (PCLK_HZ / 1000);
   localparam int FINE_STEPS = 1 << FINE_W;
   localparam int FINE_STEP_PS = TB_STEP_PS / FINE_STEPS;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] PERIOD_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] MDUTY_ADDR = 8'h08;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h0C;
   localparam logic [ADDR_W-1:0] GEN_BASE = 8'h10;
   localparam int GEN_STRIDE_SH = 4;
   localparam logic [ADDR_W-1:0] DUTY_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] PHASE_OFF = 8'h04;
   localparam logic [ADDR_W-1:0] GCFG_OFF = 8'h08;
   localparam logic [ADDR_W-1:0] TCFG_OFF = 8'h0C;

   // control register fields (main_timebase_control)
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_SYNC_EN_BIT = 1;
   localparam int CTRL_SYNC_SRC_LSB = 2;
   localparam int CTRL_HOLD_BIT = 5;
   // period sits in bits 15:3
   localparam int PERIOD_LSB = 3;
   // generator config fields
   localparam int GCFG_MASTER_BIT = 0;
   localparam int GCFG_INDEP_TB_BIT = 1;
   localparam int GCFG_OUT_INDEP_BIT = 2;
   localparam int GCFG_MATCH_LSB = 16;
   // trig_config_reg fields
   localparam int TCFG_DIV_LSB = 0;
   localparam int TCFG_START_LSB = 8;
   // status fields
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_HIGH_LSB = 4;
   localparam int STAT_TEN_LSB = 8;

   // duty extremes forcing the output
   localparam logic [DUTY_W-1:0] DUTY_ALL_OFF = 16'h0000;
   localparam logic [DUTY_W-1:0] DUTY_ALL_ON = 16'hFFFF;
   localparam logic [TB_W-1:0] TB_ZERO = 13'h0000;
   localparam logic [TB_W-1:0] TB_ONE = 13'h0001;
   localparam logic [ROLL_W-1:0] ROLL_ONE = 6'h01;
   localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
endpackage : pwm_core_pkg
`default_nettype wire

// ==== verilog/gen_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface gen_link_if;
   import pwm_core_pkg::*;
   logic run;
   logic rollover;
   logic phase_load;
   logic [TB_W-1:0] phase;
   logic [DUTY_W-1:0] duty;
   logic indep_tb;
   logic out_indep;
   logic [TB_W-1:0] trig_match;
   logic [ROLL_W-1:0] roll;
   logic [ROLL_W-1:0] start;
   logic [DIV_W-1:0] div;
   logic pwm_h;
   logic pwm_l;
   logic [FINE_W-1:0] fine;
   logic local_match;
   logic trig_pulse;
   logic trig_en;

   modport core (output run, rollover, phase_load, phase, duty, indep_tb, out_indep,
      trig_match, roll, start, div, input pwm_h, pwm_l, fine, local_match, trig_pulse, trig_en);
   modport gen (input run, rollover, phase_load, phase, duty, indep_tb, out_indep,
      trig_match, output pwm_h, pwm_l, fine, local_match);
   modport trig (input run, roll, start, div, local_match, output trig_pulse, trig_en);
endinterface : gen_link_if
`default_nettype wire

// ==== verilog/pwm_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_channel (
   input wire logic pclk,
   input wire logic presetn,
   gen_link_if.gen lk
);
   import pwm_core_pkg::*;

   logic [TB_W-1:0] cnt_r;
   logic [TB_W-1:0] cnt_nxt;
   logic [TB_W-1:0] cnt_inc;
   logic active;
   logic pwm_h_r;
   logic pwm_l_r;
   logic [FINE_W-1:0] fine_r;
   logic match_r;

   // local counter: software preset beats every load but the clear while run is low
   assign cnt_inc = cnt_r + TB_ONE;
   assign cnt_nxt = !lk.run ? TB_ZERO :                          // see R10
      lk.phase_load ? lk.phase :                                  // see R5
      lk.indep_tb ? ((cnt_r == lk.phase) ? TB_ZERO : cnt_inc) :   // see R8
      lk.rollover ? lk.phase : cnt_inc;                           // see R6 see R7

   // extremes override the compare so no sliver escapes
   assign active = lk.run && ((lk.duty == DUTY_ALL_ON) ||            // see R21
      ((lk.duty != DUTY_ALL_OFF) && (cnt_r <= lk.duty[DUTY_W-1:FINE_W]))); // see R15 see R13

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= TB_ZERO;
         pwm_h_r <= 1'b0;
         pwm_l_r <= 1'b0;
         fine_r <= '0;
         match_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         pwm_h_r <= active;
         pwm_l_r <= lk.run && (lk.out_indep ? active : !active); // see R17 see R18
         fine_r <= lk.duty[FINE_W-1:0];                          // see R24
         match_r <= lk.run && (cnt_r == lk.trig_match);
      end
   end

   assign lk.pwm_h = pwm_h_r;
   assign lk.pwm_l = pwm_l_r;
   assign lk.fine = fine_r;
   assign lk.local_match = match_r;
endmodule : pwm_channel
`default_nettype wire

// ==== verilog/trig_postscaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module trig_postscaler (
   input wire logic pclk,
   input wire logic presetn,
   gen_link_if.trig lk
);
   import pwm_core_pkg::*;

   logic en_r;
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] ratio;
   logic [DIV_W-1:0] cnt_inc;
   logic last;
   logic pulse_r;

   // a zero ratio is taken as divide by one
   assign ratio = (lk.div == '0) ? DIV_ONE : lk.div;
   assign cnt_inc = cnt_r + DIV_ONE;
   assign last = (cnt_inc >= ratio);

   // once armed, roll and start no longer matter until run drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= 1'b0;
         cnt_r <= '0;
         pulse_r <= 1'b0;
      end else begin
         en_r <= lk.run && (en_r || (lk.roll == lk.start));        // see R2 see R3 see R4
         pulse_r <= lk.run && en_r && lk.local_match && last;      // see R20
         if (!lk.run || !en_r) begin
            cnt_r <= '0;
         end else if (lk.local_match) begin
            cnt_r <= last ? '0 : cnt_inc;
         end
      end
   end

   assign lk.trig_en = en_r;
   assign lk.trig_pulse = pulse_r;
endmodule : trig_postscaler
`default_nettype wire

// ==== verilog/multi_timebase_pwm_core.sv ====
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: six-bit roll counter counts period matches, unreadable
// R2: per-generator start field arms trigger postscaler
// R3: armed postscaler ignores roll until re-enable
// R4: disable clears roll and disarms postscalers
// R5: phase register write presets local counter
// R6: primary sync keeps local counters lock-step
// R7: primary sync reloads counters with phase values
// R8: independent mode wraps at phase value
// R9: thirteen-bit counters, one count per clock
// R10: run bit starts, stops, clears all counters
// R11: period in bits 15:3, match reloads
// R12: primary cycle lasts period plus one
// R13: compare upper 13 bits, low 3 fine
// R14: per-generator duty plus shared master duty
// R15: output active while count within duty
// R16: optional duty update at primary rollover
// R17: complementary mode inverts second pin
// R18: independent output drives both pins same
// R19: counters never readable by software
// R20: trigger every N matches, N 1..7
// R21: zero duty off, all-ones duty on
// R22: external sync resets primary, match pulse out
// R23: select bit picks master or own duty
// R24: low duty bits delay falling edge finely
module multi_timebase_pwm_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pwm_core_pkg::ADDR_W-1:0] paddr,
   input wire logic [pwm_core_pkg::DATA_W-1:0] pwdata,
   output logic [pwm_core_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [pwm_core_pkg::NSRC-1:0] ext_sync_in,
   output logic sync_out,
   output logic [pwm_core_pkg::NGEN-1:0] pair_high_out,
   output logic [pwm_core_pkg::NGEN-1:0] pair_low_out,
   output logic [pwm_core_pkg::NGEN-1:0] adc_trig,
   output logic [pwm_core_pkg::NGEN*pwm_core_pkg::FINE_W-1:0] fine_delay
);
   import pwm_core_pkg::*;

   // byte address of one generator register
   function automatic logic [ADDR_W-1:0] gen_addr(input int g, input logic [ADDR_W-1:0] off);
      gen_addr = GEN_BASE + ADDR_W'(g << GEN_STRIDE_SH) + off;
   endfunction : gen_addr

   // address match for one register, used by the write strobes and the read selection
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
      hit = (a == target);
   endfunction : hit

   // global control state (main_timebase_control)
   logic module_run_bit_r;
   logic ext_sync_enable_r;
   logic [SRC_W-1:0] ext_sync_source_r;
   logic hold_r;
   logic [TB_W-1:0] main_period_value_r;
   logic [DUTY_W-1:0] mduty_sh_r;
   logic [DUTY_W-1:0] mduty_r;

   // primary time base, roll counter and sync edge
   logic [TB_W-1:0] main_timebase_count_r;
   logic [TB_W-1:0] main_timebase_count_nxt;
   logic [ROLL_W-1:0] roll_r;
   logic [ROLL_W-1:0] roll_nxt;
   logic ext_prev_r;
   logic sync_out_r;

   // per-generator software state
   logic [DUTY_W-1:0] duty_sh_r [NGEN];
   logic [DUTY_W-1:0] local_duty_value_r [NGEN];
   logic [TB_W-1:0] phase_r [NGEN];
   logic use_master_r [NGEN];
   logic indep_tb_r [NGEN];
   logic out_indep_r [NGEN];
   logic [DUTY_W-1:0] trig_match_value_r [NGEN];
   logic [DIV_W-1:0] trig_divide_ratio_r [NGEN];
   logic [ROLL_W-1:0] trig_start_select_r [NGEN];
   logic [NGEN-1:0] phase_load_r;
   logic [NGEN-1:0] trig_en_w;

   // bus decode
   logic wr_acc;
   logic rd_setup;
   logic addr_ok;
   logic [ADDR_W-GEN_STRIDE_SH-1:0] blk;
   logic [1:0] gi;
   logic [ADDR_W-1:0] sub_off;
   logic [DATA_W-1:0] ctrl_rd;
   logic [DATA_W-1:0] stat_rd;
   logic [DATA_W-1:0] gen_rd;
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] prdata_r;
   logic slverr_r;

   // primary sequencing
   logic ext_level;
   logic ext_edge;
   logic period_match;
   logic rollover;
   logic duty_load;

   // zero-wait slave: every access completes in its first access cycle
   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign blk = paddr[ADDR_W-1:GEN_STRIDE_SH];
   assign gi = 2'(blk - 1'b1);
   assign sub_off = {{(ADDR_W-GEN_STRIDE_SH){1'b0}}, paddr[GEN_STRIDE_SH-1:0]};
   assign addr_ok = (paddr[1:0] == 2'h0) && (int'(blk) <= NGEN);
   assign pready = 1'b1;
   assign pslverr = slverr_r;
   assign prdata = prdata_r;

   // read selection; no counter value ever reaches the bus
   assign ctrl_rd = RD_ZERO | (DATA_W'(module_run_bit_r) << CTRL_RUN_BIT)
      | (DATA_W'(ext_sync_enable_r) << CTRL_SYNC_EN_BIT)
      | (DATA_W'(ext_sync_source_r) << CTRL_SYNC_SRC_LSB)
      | (DATA_W'(hold_r) << CTRL_HOLD_BIT);                      // see R19
   assign stat_rd = RD_ZERO | (DATA_W'(module_run_bit_r) << STAT_RUN_BIT)
      | (DATA_W'(pair_high_out) << STAT_HIGH_LSB)
      | (DATA_W'(trig_en_w) << STAT_TEN_LSB);                    // see R1
   assign gen_rd = hit(sub_off, DUTY_OFF) ? DATA_W'(duty_sh_r[gi]) :
      hit(sub_off, PHASE_OFF) ? DATA_W'(phase_r[gi]) :
      hit(sub_off, GCFG_OFF) ? ((DATA_W'(use_master_r[gi]) << GCFG_MASTER_BIT)
         | (DATA_W'(indep_tb_r[gi]) << GCFG_INDEP_TB_BIT)
         | (DATA_W'(out_indep_r[gi]) << GCFG_OUT_INDEP_BIT)
         | (DATA_W'(trig_match_value_r[gi]) << GCFG_MATCH_LSB)) :
      ((DATA_W'(trig_divide_ratio_r[gi]) << TCFG_DIV_LSB)
         | (DATA_W'(trig_start_select_r[gi]) << TCFG_START_LSB));
   assign rd_mux = !addr_ok ? RD_ZERO :
      hit(paddr, CTRL_ADDR) ? ctrl_rd :
      hit(paddr, PERIOD_ADDR) ? (DATA_W'(main_period_value_r) << PERIOD_LSB) :
      hit(paddr, MDUTY_ADDR) ? DATA_W'(mduty_sh_r) :
      hit(paddr, STATUS_ADDR) ? stat_rd : gen_rd;

   // read data captured in setup so it stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= RD_ZERO;
         slverr_r <= 1'b0;
      end else if (rd_setup) begin
         prdata_r <= pwrite ? RD_ZERO : rd_mux;
         slverr_r <= !addr_ok;
      end
   end

   // global registers; period and duty writable at any moment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_run_bit_r <= 1'b0;
         ext_sync_enable_r <= 1'b0;
         ext_sync_source_r <= '0;
         hold_r <= 1'b0;
         main_period_value_r <= TB_ZERO;
         mduty_sh_r <= DUTY_ALL_OFF;
      end else if (wr_acc) begin
         if (hit(paddr, CTRL_ADDR)) begin
            module_run_bit_r <= pwdata[CTRL_RUN_BIT];                  // see R10
            ext_sync_enable_r <= pwdata[CTRL_SYNC_EN_BIT];
            ext_sync_source_r <= pwdata[CTRL_SYNC_SRC_LSB +: SRC_W];
            hold_r <= pwdata[CTRL_HOLD_BIT];
         end
         if (hit(paddr, PERIOD_ADDR)) begin
            main_period_value_r <= pwdata[PERIOD_LSB +: TB_W];        // see R11 see R12
         end
         if (hit(paddr, MDUTY_ADDR)) begin
            mduty_sh_r <= pwdata[DUTY_W-1:0];                         // see R14
         end
      end
   end

   // primary rollover: period match or a rising edge on the chosen sync input
   assign ext_level = ext_sync_in[ext_sync_source_r];
   assign ext_edge = ext_sync_enable_r && ext_level && !ext_prev_r;        // see R22
   assign period_match = module_run_bit_r && (main_timebase_count_r == main_period_value_r);
   assign rollover = module_run_bit_r && (period_match || ext_edge);
   // counter spans zero..period, so a cycle is period plus one counts
   assign main_timebase_count_nxt = (!module_run_bit_r || rollover) ? TB_ZERO :
      main_timebase_count_r + TB_ONE;                                     // see R9 see R12
   assign roll_nxt = !module_run_bit_r ? '0 :
      period_match ? roll_r + ROLL_ONE : roll_r;                          // see R1 see R4
   // without hold the shadow passes straight through, one cycle later
   assign duty_load = !hold_r || rollover;                                // see R16

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_timebase_count_r <= TB_ZERO;
         roll_r <= '0;
         ext_prev_r <= 1'b0;
         sync_out_r <= 1'b0;
         mduty_r <= DUTY_ALL_OFF;
      end else begin
         main_timebase_count_r <= main_timebase_count_nxt;
         roll_r <= roll_nxt;
         ext_prev_r <= ext_level;
         sync_out_r <= period_match;                                      // see R22
         if (duty_load) begin
            mduty_r <= mduty_sh_r;
         end
      end
   end
   assign sync_out = sync_out_r;

   // one channel and one trigger postscaler per generator
   for (genvar g = 0; g < NGEN; g++) begin : gen_ch
      gen_link_if lk ();
      logic wr_duty;
      logic wr_phase;
      logic wr_gcfg;
      logic wr_tcfg;

      assign wr_duty = wr_acc && hit(paddr, gen_addr(g, DUTY_OFF));
      assign wr_phase = wr_acc && hit(paddr, gen_addr(g, PHASE_OFF));
      assign wr_gcfg = wr_acc && hit(paddr, gen_addr(g, GCFG_OFF));
      assign wr_tcfg = wr_acc && hit(paddr, gen_addr(g, TCFG_OFF));

      // software side of the generator
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            duty_sh_r[g] <= DUTY_ALL_OFF;
            local_duty_value_r[g] <= DUTY_ALL_OFF;
            phase_r[g] <= TB_ZERO;
            phase_load_r[g] <= 1'b0;
            use_master_r[g] <= 1'b0;
            indep_tb_r[g] <= 1'b0;
            out_indep_r[g] <= 1'b0;
            trig_match_value_r[g] <= DUTY_ALL_OFF;
            trig_divide_ratio_r[g] <= '0;
            trig_start_select_r[g] <= '0;
         end else begin
            phase_load_r[g] <= wr_phase;                                  // see R5
            if (duty_load) begin
               local_duty_value_r[g] <= duty_sh_r[g];                     // see R16
            end
            if (wr_duty) begin
               duty_sh_r[g] <= pwdata[DUTY_W-1:0];                        // see R14
            end
            if (wr_phase) begin
               phase_r[g] <= pwdata[TB_W-1:0];
            end
            if (wr_gcfg) begin
               use_master_r[g] <= pwdata[GCFG_MASTER_BIT];                // see R23
               indep_tb_r[g] <= pwdata[GCFG_INDEP_TB_BIT];
               out_indep_r[g] <= pwdata[GCFG_OUT_INDEP_BIT];
               trig_match_value_r[g] <= pwdata[GCFG_MATCH_LSB +: DUTY_W];
            end
            if (wr_tcfg) begin
               trig_divide_ratio_r[g] <= pwdata[TCFG_DIV_LSB +: DIV_W];
               trig_start_select_r[g] <= pwdata[TCFG_START_LSB +: ROLL_W];  // see R2
            end
         end
      end

      // the phase preset takes the value just written
      assign lk.run = module_run_bit_r;
      assign lk.rollover = rollover;                                      // see R6 see R7
      assign lk.phase_load = phase_load_r[g];
      assign lk.phase = phase_r[g];
      assign lk.duty = use_master_r[g] ? mduty_r : local_duty_value_r[g]; // see R23
      assign lk.indep_tb = indep_tb_r[g];                                 // see R8
      assign lk.out_indep = out_indep_r[g];
      assign lk.trig_match = trig_match_value_r[g][DUTY_W-1:FINE_W];
      assign lk.roll = roll_r;
      assign lk.start = trig_start_select_r[g];
      assign lk.div = trig_divide_ratio_r[g];

      pwm_channel u_ch (
         .pclk(pclk),
         .presetn(presetn),
         .lk(lk)
      );

      trig_postscaler u_trig (
         .pclk(pclk),
         .presetn(presetn),
         .lk(lk)
      );

      // outputs leave straight from the channel and postscaler flip-flops
      assign pair_high_out[g] = lk.pwm_h;
      assign pair_low_out[g] = lk.pwm_l;
      assign adc_trig[g] = lk.trig_pulse;
      assign trig_en_w[g] = lk.trig_en;
      assign fine_delay[g*FINE_W +: FINE_W] = lk.fine;                    // see R13 see R24
   end
endmodule : multi_timebase_pwm_core
`default_nettype wire

// ==== test/pwm_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_core_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pwm_core_pkg::ADDR_W-1:0] paddr,
   input wire logic [pwm_core_pkg::DATA_W-1:0] pwdata,
   input wire logic [pwm_core_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [pwm_core_pkg::NSRC-1:0] ext_sync_in,
   input wire logic sync_out,
   input wire logic [pwm_core_pkg::NGEN-1:0] pair_high_out,
   input wire logic [pwm_core_pkg::NGEN-1:0] pair_low_out,
   input wire logic [pwm_core_pkg::NGEN-1:0] adc_trig,
   input wire logic [pwm_core_pkg::NGEN*pwm_core_pkg::FINE_W-1:0] fine_delay
);
   import pwm_core_pkg::*;
   logic run_r;
   logic sen_r;
   logic seen_r;
   logic [TB_W-1:0] per_r;
   logic [TB_W:0] gap_r;
   // decode of completed writes, as the slave sees them
   wire logic wr_done = psel && penable && pwrite;
   wire logic ctl_wr = wr_done && (paddr == CTRL_ADDR);
   wire logic per_wr = wr_done && (paddr == PERIOD_ADDR);
   wire logic bad_addr = (paddr[1:0] != 2'h0) || (paddr[7:4] > 4'h4);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // shadow of run and period; a control or period write voids the interval in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'h0;
         sen_r <= 1'h0;
         seen_r <= 1'h0;
         per_r <= '0;
         gap_r <= '0;
      end else begin
         if (ctl_wr) begin
            run_r <= pwdata[CTRL_RUN_BIT];
            sen_r <= pwdata[CTRL_SYNC_EN_BIT];
         end
         if (per_wr) begin
            per_r <= pwdata[PERIOD_LSB +: TB_W];
         end
         gap_r <= sync_out ? 14'h0001 : gap_r + 14'h0001;
         seen_r <= (ctl_wr || per_wr || !run_r) ? 1'h0 : (sync_out || seen_r);
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_stop;
      ctl_wr && !pwdata[CTRL_RUN_BIT];
   endsequence
   AST_READY: assert property (pready)
      else $error("pready low");
   AST_ERR: assert property (s_setup ##1 penable |-> pslverr == $past(bad_addr))
      else $error("pslverr wrong");
   AST_ZERO: assert property (psel && !penable && (pwrite || bad_addr) |=> prdata == RD_ZERO)
      else $error("prdata not zero");
   AST_STATUS_RUN: assert property (s_setup ##0 (!pwrite && paddr == STATUS_ADDR)
      |=> prdata[STAT_RUN_BIT] == run_r)
      else $error("status run bit wrong");
   AST_STOP: assert property (s_stop |=> ##2 (pair_high_out == '0 && pair_low_out == '0
      && adc_trig == '0 && !sync_out)[*2])
      else $error("outputs live after stop");
   AST_SYNC_ONE: assert property (sync_out && per_r != '0 |=> !sync_out)
      else $error("sync pulse too long");
   AST_SYNC_GAP: assert property (sync_out && seen_r && !sen_r |-> gap_r == {1'h0, per_r} + 14'h0001)
      else $error("primary cycle length wrong");
   AST_TRIG_ONE: assert property (adc_trig != '0 |=> (adc_trig & $past(adc_trig)) == '0)
      else $error("trigger pulse too long");
endmodule : pwm_core_props
bind multi_timebase_pwm_core pwm_core_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_sync_in, .sync_out, .pair_high_out,
   .pair_low_out, .adc_trig, .fine_delay);
`default_nettype wire

// ==== test/gate_drive_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gate_drive_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [pwm_core_pkg::NGEN-1:0] high_in,
   input wire logic [pwm_core_pkg::NGEN-1:0] low_in,
   input wire logic [pwm_core_pkg::NGEN-1:0] trig_in,
   output logic [pwm_core_pkg::NGEN-1:0][15:0] hi_cnt,
   output logic [pwm_core_pkg::NGEN-1:0][15:0] eq_cnt,
   output logic [pwm_core_pkg::NGEN-1:0][15:0] trig_cnt
);
   import pwm_core_pkg::*;
   // on cycles, equal-gate cycles (shoot-through risk), conversions; an unknown poisons a count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt <= '0;
         eq_cnt <= '0;
         trig_cnt <= '0;
      end else begin
         for (int g = 0; g < NGEN; g++) begin
            hi_cnt[g] <= hi_cnt[g] + 16'(high_in[g]);
            eq_cnt[g] <= eq_cnt[g] + 16'(low_in[g] == high_in[g]);
            trig_cnt[g] <= trig_cnt[g] + 16'(trig_in[g]);
         end
      end
   end
endmodule : gate_drive_model
`default_nettype wire

// ==== test/tb_multi_timebase_pwm_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_multi_timebase_pwm_core;
   import pwm_core_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_out, e;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, q;
   logic [NSRC-1:0] ext_sync_in;
   logic [NGEN-1:0] pair_high_out, pair_low_out, adc_trig;
   logic [NGEN*FINE_W-1:0] fine_delay;
   logic [NGEN-1:0][15:0] hi_cnt, eq_cnt, trig_cnt, h0, e0, t0;
   int mismatches, checks_done, cyc;
   multi_timebase_pwm_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_sync_in, .sync_out, .pair_high_out, .pair_low_out,
      .adc_trig, .fine_delay);
   gate_drive_model u_drv (.pclk, .presetn, .high_in(pair_high_out), .low_in(pair_low_out),
      .trig_in(adc_trig), .hi_cnt, .eq_cnt, .trig_cnt);
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end
   // hang guard, far above the roughly five hundred cycles the tests need
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask : chk
   // one transfer, held until pready is seen high; idle edge after release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   function automatic logic [7:0] ga(input int g, input logic [7:0] off);
      return GEN_BASE + 8'(g << GEN_STRIDE_SH) + off;
   endfunction : ga
   task automatic win(input int n);
      h0 = hi_cnt;
      e0 = eq_cnt;
      t0 = trig_cnt;
      repeat (n) @(posedge pclk);
   endtask : win
   task automatic t_regs();
      apb(1'h0, CTRL_ADDR, 32'h0);
      chk(q, 32'h0, "ctrl after reset");
      apb(1'h0, 8'h50, 32'h0);
      chk({q[30:0], e}, 32'h1, "unmapped read");
      $display("test regs done");
   endtask : t_regs
   task automatic t_duty();
      logic [15:0] eh [NGEN] = '{16'h5, 16'hA, 16'h0, 16'h3};
      logic [15:0] ee [NGEN] = '{16'h0, 16'h0, 16'h0, 16'hA};
      logic [39:0] w [8] = '{{PERIOD_ADDR, 32'h48}, {MDUTY_ADDR, 32'hFFFF}, {8'h10, 32'h23},
         {8'h28, 32'h1}, {8'h30, 32'h0}, {8'h40, 32'h10}, {8'h48, 32'h4}, {CTRL_ADDR, 32'h1}};
      foreach (w[i]) apb(1'h1, w[i][39:32], w[i][31:0]);
      win(30);
      win(10);
      for (int g = 0; g < NGEN; g++) begin
         chk(32'(hi_cnt[g] - h0[g]), 32'(eh[g]), "active cycles");
         chk(32'(eq_cnt[g] - e0[g]), 32'(ee[g]), "pair relation");
      end
      chk(32'(fine_delay[2:0]), 32'h3, "fine bits");
      $display("test duty done");
   endtask : t_duty
   task automatic t_hold();
      apb(1'h1, CTRL_ADDR, 32'h21);
      while (sync_out !== 1'h1) @(posedge pclk);
      apb(1'h1, ga(0, DUTY_OFF), 32'h43);
      win(5);
      chk(32'(hi_cnt[0] - h0[0] < 16'h4), 32'h1, "held duty");
      win(12);
      win(10);
      chk(32'(hi_cnt[0] - h0[0]), 32'h9, "duty after rollover");
      apb(1'h1, CTRL_ADDR, 32'h1);
      // indep mode first, then the phase write presets the counter onto its wrap value
      apb(1'h1, ga(2, DUTY_OFF), 32'h8);
      apb(1'h1, ga(2, GCFG_OFF), 32'h2);
      apb(1'h1, ga(2, PHASE_OFF), 32'h4);
      win(20);
      win(10);
      chk(32'(hi_cnt[2] - h0[2]), 32'h4, "own wrap");
      $display("test hold and phase done");
   endtask : t_hold
   task automatic t_trig();
      logic [15:0] et [NGEN] = '{16'h7, 16'h15, 16'h3, 16'h15};
      logic [31:0] gc [NGEN] = '{32'h0010_0000, 32'h0010_0001, 32'h0058_0000, 32'h0010_0004};
      logic [31:0] tc [NGEN] = '{32'h0203, 32'h1, 32'h7, 32'h0};
      apb(1'h1, CTRL_ADDR, 32'h0);
      @(posedge pclk);
      win(10);
      chk(32'(hi_cnt[1] - h0[1]), 32'h0, "stopped output");
      for (int g = 0; g < NGEN; g++) begin
         apb(1'h1, ga(g, GCFG_OFF), gc[g]);
         apb(1'h1, ga(g, TCFG_OFF), tc[g]);
      end
      apb(1'h1, CTRL_ADDR, 32'h1);
      apb(1'h0, STATUS_ADDR, 32'h0);
      chk(32'(q[STAT_TEN_LSB +: NGEN]), 32'hE, "armed at start");
      win(40);
      apb(1'h1, ga(0, TCFG_OFF), 32'h3F03);
      win(210);
      for (int g = 0; g < NGEN; g++) begin
         chk(32'(trig_cnt[g] - t0[g]), 32'(et[g]), "trigger count");
      end
      // sync edge every other cycle pins the primary and phase-zero counters to 0..1
      apb(1'h1, CTRL_ADDR, 32'h7);
      h0 = hi_cnt;
      repeat (20) @(posedge pclk) ext_sync_in[1] <= ~ext_sync_in[1];
      chk(32'(hi_cnt[3] - h0[3]), 32'h12, "ext sync reset");
      apb(1'h1, CTRL_ADDR, 32'h0);
      apb(1'h0, STATUS_ADDR, 32'h0);
      chk(32'(q[STAT_TEN_LSB +: NGEN]), 32'h0, "disarmed");
      $display("test trigger done");
   endtask : t_trig
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = '0;
      pwdata = '0;
      ext_sync_in = '0;
      mismatches = 0;
      checks_done = 0;
      cyc = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_regs();
      t_duty();
      t_hold();
      t_trig();
      final_report();
   end
endmodule : tb_multi_timebase_pwm_core
`default_nettype wire
